// File: retimer_ctl.v
// mode and configuration control of an hdmi link retimer
// ==========================================================
`timescale 1ns/1ns
`include "retimer_ctl_consts.vh"
module retimer_ctl #(
   parameter LOCK_CYCLES = `LOCK_CYCLES
) (
   // clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // straps: a floating strap is seen as pull-up and pull-down disagreeing
   input  wire       eq_select_strap_pu,
   input  wire       eq_select_strap_pd,
   input  wire       transmit_termination_strap_pu,
   input  wire       transmit_termination_strap_pd,
   input  wire       deemph_strap,
   input  wire       signal_detect_enable,
   // host configuration
   input  wire       host_wr,
   input  wire [1:0] host_eq_mode,
   input  wire       host_eq_valid,
   input  wire       host_sigdet_en,
   input  wire       host_sigdet_valid,
   input  wire       host_audio_disable,
   input  wire [1:0] host_deemph,
   input  wire [2:0] host_swing,
   input  wire       host_outctl_valid,
   input  wire [1:0] function_mode_field,
   input  wire       host_blank_on_relock,
   input  wire       host_force_lock,
   input  wire [7:0] host_ddc_rate,
   // link
   input  wire       link_clk,
   input  wire       spdif_in,
   // link control outputs
   output reg        audio_return_output,
   output reg        standby,
   output reg        link_out_oe,
   output reg        rx_term_en,
   output reg        tx_term_en,
   output reg        cdr_en,
   output reg        retimer_active,
   output reg        locked,
   output reg  [1:0] eq_mode,
   output reg  [7:0] eq_gain,
   output reg  [1:0] deemph,
   output reg  [2:0] swing,
   // upstream ddc
   input  wire       upstream_ddc_clock,
   input  wire       upstream_ddc_data,
   output reg        upstream_ddc_clock_oe,
   output reg        upstream_ddc_data_oe,
   // downstream ddc
   input  wire       downstream_ddc_clock,
   input  wire       downstream_ddc_data,
   output reg        downstream_ddc_clock_oe,
   output reg        downstream_ddc_data_oe
);
   // ==========================================================
   // input synchronisers
   wire [11:0] raw_in;
   wire [11:0] syn;
   assign raw_in = {spdif_in, link_clk, upstream_ddc_clock, upstream_ddc_data,
                    downstream_ddc_clock, downstream_ddc_data, eq_select_strap_pu,
                    eq_select_strap_pd, transmit_termination_strap_pu,
                    transmit_termination_strap_pd, deemph_strap, signal_detect_enable};
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi = gi + 1) begin : g_sync
         // ddc lines idle high; resetting their stages high avoids a false edge after reset
         sync3 #(.RST_VAL(((gi >= 6) && (gi <= 9)) ? 1'b1 : 1'b0)) u_sync (
            .clk    (clk),
            .arst_n (arst_n),
            .din    (raw_in[gi]),
            .dout   (syn[gi])
         );
      end
   endgenerate
   wire s_spdif  = syn[11];
   wire s_lclk   = syn[10];
   wire s_uscl   = syn[9];
   wire s_usda   = syn[8];
   wire s_dscl   = syn[7];
   wire s_dsda   = syn[6];
   wire s_sigen  = syn[0];

   // strap decode: pull-up high and pull-down high means driven high, etc.
   function [1:0] strap_level;
      input pu;
      input pd;
      begin
         if (pu && pd)
            strap_level = `STRAP_HIGH;
         else if (!pu && !pd)
            strap_level = `STRAP_LOW;
         else
            strap_level = `STRAP_FLOAT;
      end
   endfunction
   wire [1:0] eq_strap   = strap_level(syn[5], syn[4]);
   wire [1:0] term_strap = strap_level(syn[3], syn[2]);

   // ==========================================================
   // host override latches; once written the host value wins
   reg        own_eq;
   reg        own_sd;
   reg        own_oc;
   reg [1:0]  h_eq;
   reg        h_sd;
   reg [1:0]  h_de;
   reg [2:0]  h_sw;
   reg        h_arc_off;
   reg [1:0]  h_fmode;
   reg        h_blank;
   reg        h_force;
   reg [7:0]  h_rate;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         own_eq    <= 1'b0;
         own_sd    <= 1'b0;
         own_oc    <= 1'b0;
         h_eq      <= `EQ_ADAPTIVE;
         h_sd      <= 1'b0;
         h_de      <= `DEEMPH_0DB;
         h_sw      <= 3'h0;
         h_arc_off <= 1'b0;
         h_fmode   <= `FMODE_AUTO;
         h_blank   <= 1'b0;
         h_force   <= 1'b0;
         h_rate    <= `DDC_RATE_100K;
      end else if (host_wr) begin
         if (host_eq_valid) begin
            own_eq <= 1'b1;
            h_eq   <= host_eq_mode;
         end
         if (host_sigdet_valid) begin
            own_sd <= 1'b1;
            h_sd   <= host_sigdet_en;
         end
         if (host_outctl_valid) begin
            own_oc <= 1'b1;
            h_de   <= host_deemph;
            h_sw   <= host_swing;
         end
         h_arc_off <= host_audio_disable;
         h_fmode   <= function_mode_field;
         h_blank   <= host_blank_on_relock;
         h_force   <= host_force_lock;
         h_rate    <= host_ddc_rate;
      end
   end

   // ==========================================================
   // link clock presence and rate measurement
   reg        lclk_d;
   reg [6:0]  idle_cnt;
   reg        clk_valid;
   reg [10:0] win_cnt;
   reg [15:0] edge_cnt;
   reg [15:0] rate;
   reg [15:0] prev_rate;
   wire       lclk_rise = s_lclk & ~lclk_d;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lclk_d    <= 1'b0;
         idle_cnt  <= 7'h00;
         clk_valid <= 1'b0;
         win_cnt   <= 11'h000;
         edge_cnt  <= 16'h0000;
         rate      <= 16'h0000;
         prev_rate <= 16'h0000;
      end else begin
         lclk_d <= s_lclk;
         if (lclk_rise) begin
            idle_cnt  <= 7'h00;
            clk_valid <= 1'b1;
         end else if (idle_cnt == `LINK_IDLE_LAST) begin
            clk_valid <= 1'b0;
         end else begin
            idle_cnt <= idle_cnt + 7'h01;
         end
         if (win_cnt == `RATE_WIN_LAST) begin
            win_cnt   <= 11'h000;
            prev_rate <= rate;
            // an edge on the closing cycle still belongs to this window
            rate      <= edge_cnt + {15'h0000, lclk_rise};
            edge_cnt  <= 16'h0000;
         end else begin
            win_cnt <= win_cnt + 11'h001;
            if (lclk_rise)
               edge_cnt <= edge_cnt + 16'h0001;
         end
      end
   end

   // ==========================================================
   // operating mode and lock acquisition
   wire sd_on    = own_sd ? h_sd : s_sigen;
   wire sleeping = sd_on & ~clk_valid;
   wire fast     = rate >= `RATE_RETIMER_TH;
   reg  next_ret;
   always @* begin
      case (h_fmode)
         `FMODE_REDRIVER: next_ret = 1'b0;
         `FMODE_RETIMER:  next_ret = 1'b1;
         default:         next_ret = fast;
      endcase
   end
   reg  [31:0] lock_cnt;
   reg         relocking;
   wire        rate_jump = (rate[15:4] != prev_rate[15:4]);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_cnt  <= 32'h00000000;
         relocking <= 1'b0;
      end else if (!next_ret || sleeping) begin
         lock_cnt  <= 32'h00000000;
         relocking <= 1'b0;
      end else if (h_force) begin
         // jitter test path: host holds the pll in lock
         relocking <= 1'b0;
      end else if (rate_jump || (!retimer_active && !relocking && !locked)) begin
         lock_cnt  <= 32'h00000000;
         relocking <= 1'b1;
      end else if (relocking) begin
         if (lock_cnt == LOCK_CYCLES - 1)
            relocking <= 1'b0;
         else
            lock_cnt <= lock_cnt + 32'h00000001;
      end
   end

   // ==========================================================
   // registered control outputs
   wire [1:0] eq_sel = own_eq ? h_eq : eq_strap;
   wire [1:0] deemph_strap_sel = syn[1] ? `DEEMPH_0DB : `DEEMPH_2DB;
   wire [1:0] de_sel = own_oc ? h_de : deemph_strap_sel;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         audio_return_output <= 1'b0;
         standby             <= 1'b0;
         link_out_oe         <= 1'b0;
         rx_term_en          <= 1'b0;
         tx_term_en          <= 1'b0;
         cdr_en              <= 1'b0;
         retimer_active      <= 1'b0;
         locked              <= 1'b0;
         eq_mode             <= `EQ_ADAPTIVE;
         eq_gain             <= 8'h00;
         deemph              <= `DEEMPH_0DB;
         swing               <= 3'h0;
      end else begin
         audio_return_output <= s_spdif & ~h_arc_off;
         standby             <= sleeping;
         rx_term_en          <= ~sleeping;
         retimer_active      <= next_ret & ~sleeping;
         cdr_en              <= next_ret & ~sleeping;
         locked              <= next_ret & ~sleeping & (h_force | (~relocking & ~rate_jump & retimer_active));
         link_out_oe         <= ~sleeping & ~(relocking & h_blank);
         case (term_strap)
            `STRAP_FLOAT: tx_term_en <= ~sleeping & (rate >= `RATE_TERM_TH);
            default:      tx_term_en <= 1'b0;
         endcase
         eq_mode <= (eq_sel == `STRAP_HIGH) ? `EQ_FIXED_HIGH :
                    (eq_sel == `STRAP_LOW)  ? `EQ_FIXED_LOW  : `EQ_ADAPTIVE;
         case (eq_sel)
            `STRAP_HIGH: eq_gain <= `EQ_GAIN_HIGH;
            `STRAP_LOW:  eq_gain <= `EQ_GAIN_LOW;
            default:     eq_gain <= fast ? `EQ_GAIN_HIGH : `EQ_GAIN_LOW;
         endcase
         deemph <= (next_ret & ~sleeping) ? de_sel : `DEEMPH_0DB;
         swing  <= own_oc ? h_sw : 3'h0;
      end
   end

   // ==========================================================
   // ddc bridge: forward after start, return sink data, stretch clock
   localparam DS_IDLE = 2'h0;
   localparam DS_FWD  = 2'h1;
   reg [1:0]  ddc_st;
   reg        usda_d;
   reg [15:0] bit_cnt;
   reg        paced;
   reg [2:0]  dn_hold;
   reg [2:0]  up_hold;
   wire [15:0] div = (h_rate == `DDC_RATE_400K) ? `DDC_DIV_400K : `DDC_DIV_100K;
   wire start_c = usda_d & ~s_usda & s_uscl;
   wire stop_c  = ~usda_d & s_usda & s_uscl;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ddc_st                  <= DS_IDLE;
         usda_d                  <= 1'b1;
         bit_cnt                 <= 16'h0000;
         paced                   <= 1'b0;
         dn_hold                 <= 3'h0;
         up_hold                 <= 3'h0;
         upstream_ddc_clock_oe   <= 1'b0;
         upstream_ddc_data_oe    <= 1'b0;
         downstream_ddc_clock_oe <= 1'b0;
         downstream_ddc_data_oe  <= 1'b0;
      end else begin
         usda_d <= s_usda;
         // our own release reads back low for a few cycles; without a hold-off it would echo back
         dn_hold <= downstream_ddc_data_oe ? `DDC_ECHO_HOLD : (dn_hold != 3'h0) ? dn_hold - 3'h1 : 3'h0;
         up_hold <= upstream_ddc_data_oe ? `DDC_ECHO_HOLD : (up_hold != 3'h0) ? up_hold - 3'h1 : 3'h0;
         case (ddc_st)
            DS_IDLE: begin
               upstream_ddc_clock_oe   <= 1'b0;
               upstream_ddc_data_oe    <= 1'b0;
               downstream_ddc_clock_oe <= 1'b0;
               downstream_ddc_data_oe  <= 1'b0;
               if (start_c) begin
                  ddc_st                 <= DS_FWD;
                  downstream_ddc_data_oe <= 1'b1;
               end
            end
            DS_FWD: begin
               // pace low phases to the selected rate
               if (s_uscl)
                  bit_cnt <= 16'h0000;
               else if (bit_cnt != div)
                  bit_cnt <= bit_cnt + 16'h0001;
               paced <= (bit_cnt == div);
               // released once paced, so the sink may stretch before the source is let go
               downstream_ddc_clock_oe <= ~s_uscl & ~paced;
               // stretch the source clock while the sink holds its clock low
               upstream_ddc_clock_oe   <= ~s_uscl ? (~s_dscl | ~paced) : 1'b0;
               downstream_ddc_data_oe  <= ~s_usda & ~upstream_ddc_data_oe & (up_hold == 3'h0);
               upstream_ddc_data_oe    <= ~s_dsda & ~downstream_ddc_data_oe & (dn_hold == 3'h0);
               if (stop_c)
                  ddc_st <= DS_IDLE;
            end
            default: ddc_st <= DS_IDLE;
         endcase
      end
   end
endmodule // retimer_ctl

// File: retimer_ctl_consts.vh
// constants for the retimer mode control block
`ifndef RETIMER_CTL_CONSTS_VH
`define RETIMER_CTL_CONSTS_VH
// ==========================================================
// clock and timing
`define CLK_HZ            50000000
`define LOCK_TIME_US      7000
`define LOCK_CYCLES       ((`CLK_HZ / 1000000) * `LOCK_TIME_US)
`define LINK_TIMEOUT_CYC  64
`define RATE_WINDOW_CYC   1024
// last count values of the two counters: timeout minus one, window minus one
`define LINK_IDLE_LAST    7'h3F
`define RATE_WIN_LAST     11'h3FF
// ==========================================================
// link clock edges per rate window; the window lasts 20.48 us
// 100 MHz pixel scaled: counts reported by the prescaled link clock input
`define RATE_RETIMER_TH   16'h0080
`define RATE_TERM_TH      16'h0100
// ==========================================================
// equalizer encodings
`define EQ_FIXED_LOW      2'h0
`define EQ_FIXED_HIGH     2'h1
`define EQ_ADAPTIVE       2'h2
// equalizer gains in tenths of dB
`define EQ_GAIN_HIGH      8'h64
`define EQ_GAIN_LOW       8'h4B
// ==========================================================
// strap tri-level codes
`define STRAP_LOW         2'h0
`define STRAP_HIGH        2'h1
`define STRAP_FLOAT       2'h2
// ==========================================================
// function mode field values
`define FMODE_REDRIVER    2'h0
`define FMODE_RETIMER     2'h1
`define FMODE_AUTO        2'h2
// ==========================================================
// output control field values
`define DEEMPH_0DB        2'h0
`define DEEMPH_2DB        2'h1
`define SWING_BOOST       3'h3
// ==========================================================
// ddc rate codes
`define DDC_RATE_100K     8'h00
`define DDC_RATE_400K     8'h01
`define DDC_DIV_100K      16'h00FA
`define DDC_DIV_400K      16'h003E
// cycles a released ddc line is ignored while its synchroniser catches up
`define DDC_ECHO_HOLD     3'h6
`endif

// File: sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module sync3 #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input  wire clk,
   input  wire arst_n,
   // data
   input  wire din,
   output reg  dout
);
   reg s1;
   reg s2;
   reg s3;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1   <= RST_VAL;
         s2   <= RST_VAL;
         s3   <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         // change counts once the second and third stages agree
         if (s2 == s3)
            dout <= s3;
      end
   end
endmodule // sync3

// File: retimer_ctl_monitor.sv
// concurrent checks on the retimer_ctl ports
`timescale 1ns/1ns
module retimer_ctl_monitor (
   // clock and reset
   input wire       clk,
   input wire       arst_n,
   // causes
   input wire       host_wr,
   input wire [1:0] function_mode_field,
   input wire       transmit_termination_strap_pu,
   input wire       transmit_termination_strap_pd,
   // effects
   input wire       standby,
   input wire       link_out_oe,
   input wire       rx_term_en,
   input wire       tx_term_en,
   input wire       cdr_en,
   input wire       retimer_active,
   input wire [1:0] eq_mode,
   input wire [7:0] eq_gain,
   input wire [1:0] deemph
);
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // mode writes: a lone write, not overtaken by a second one
   sequence fm_write(v);
      host_wr && function_mode_field == v ##1 !host_wr;
   endsequence
   // ==========================================================
   // assertions
   a_standby_outs_off: assert property (standby |-> !link_out_oe && !cdr_en)
      else $error("link outputs live during standby");
   a_term_awake: assert property (rx_term_en |-> !standby)
      else $error("input termination on during standby");
   a_redrv_no_deemph: assert property (!retimer_active |-> deemph == 2'h0)
      else $error("de-emphasis applied as redriver");
   a_eq_high_gain: assert property ((eq_mode == 2'h1) [*2] |-> eq_gain == 8'h64)
      else $error("fixed high equalizer gain wrong");
   a_eq_low_gain: assert property ((eq_mode == 2'h0) [*2] |-> eq_gain == 8'h4B)
      else $error("fixed low equalizer gain wrong");
   a_force_redrv: assert property (fm_write(2'h0) |-> ##1 !retimer_active && !cdr_en)
      else $error("forced redriver still retiming");
   a_force_retime: assert property (fm_write(2'h1) ##0 !standby |-> ##[1:6] retimer_active)
      else $error("forced retimer not entered");
   a_term_strap_off: assert property
      ((transmit_termination_strap_pu && transmit_termination_strap_pd) [*8] |-> !tx_term_en)
      else $error("output termination on with strap high");
endmodule // retimer_ctl_monitor

bind retimer_ctl retimer_ctl_monitor retimer_ctl_monitor_i (.*);

// File: hdmi_far_side.sv
// far side model: source link clock and a ddc sink
`timescale 1ns/1ns
module hdmi_far_side (
   // bench control
   input  wire run,
   input  wire slow,
   input  wire sink_pull,
   // design pins
   input  wire dn_oe,
   output reg  link_clk,
   output wire dn_data
);
   // the link clock stands still between frames
   initial begin
      link_clk = 1'b0;
      forever begin
         if (run) begin
            #(slow ? 320 : 80);
            link_clk = ~link_clk;
         end else begin
            #10;
            link_clk = 1'b0;
         end
      end
   end
   // pulled-up line: either party may pull it low, e.g. the sink acknowledge
   assign dn_data = !(dn_oe || sink_pull);
endmodule // hdmi_far_side

// File: retimer_ctl_tb.sv
// self-checking bench for retimer_ctl
`timescale 1ns/1ns
`include "retimer_ctl_consts.vh"
module retimer_ctl_tb;
   typedef struct {logic pu; logic pd; logic hw; logic [1:0] hm; logic [1:0] em; logic [7:0] eg;} row_t;
   // ==========================================================
   // stimulus
   logic clk = 0, arst_n = 0, eq_select_strap_pu = 0, eq_select_strap_pd = 0;
   logic transmit_termination_strap_pu = 1, transmit_termination_strap_pd = 1;
   logic deemph_strap = 0, signal_detect_enable = 0, host_wr = 0, host_eq_valid = 0;
   logic host_sigdet_en = 0, host_sigdet_valid = 0, host_audio_disable = 0, host_outctl_valid = 0;
   logic host_blank_on_relock = 0, host_force_lock = 0, spdif_in = 0;
   logic run = 0, slow = 0, sink_pull = 0, src_pull = 0, src_clk_pull = 0;
   logic [1:0] host_eq_mode = 0, host_deemph = 0, function_mode_field = `FMODE_AUTO;
   logic [2:0] host_swing = 0;
   logic [7:0] host_ddc_rate = `DDC_RATE_100K;
   // ==========================================================
   // responses and wires
   wire audio_return_output, standby, link_out_oe, rx_term_en, tx_term_en, cdr_en, retimer_active, locked;
   wire upstream_ddc_clock_oe, upstream_ddc_data_oe, downstream_ddc_clock_oe, downstream_ddc_data_oe;
   wire link_clk, downstream_ddc_data;
   wire [1:0] eq_mode, deemph;
   wire [7:0] eq_gain;
   wire [2:0] swing;
   wire upstream_ddc_clock = !(upstream_ddc_clock_oe || src_clk_pull);
   wire upstream_ddc_data = !(upstream_ddc_data_oe || src_pull);
   wire downstream_ddc_clock = !downstream_ddc_clock_oe;
   int err_total = 0, compares = 0, cycles = 0;
   row_t rows[4] = '{'{1, 1, 0, 0, `EQ_FIXED_HIGH, `EQ_GAIN_HIGH}, '{0, 0, 0, 0, `EQ_FIXED_LOW, `EQ_GAIN_LOW},
                     '{1, 0, 0, 0, `EQ_ADAPTIVE, 8'h00}, '{1, 1, 1, `EQ_FIXED_LOW, `EQ_FIXED_LOW, `EQ_GAIN_LOW}};

   // short lock count keeps the run brief
   retimer_ctl #(.LOCK_CYCLES(50)) retimer_ctl_i (.*);
   hdmi_far_side hdmi_far_side_i (.run(run), .slow(slow), .sink_pull(sink_pull),
      .dn_oe(downstream_ddc_data_oe), .link_clk(link_clk), .dn_data(downstream_ddc_data));

   initial begin
      forever #10 clk = ~clk;
   end
   // ==========================================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic host_write;
      host_wr = 1'b1;
      tick(1);
      host_wr = 1'b0;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // hang guard, well above the expected seven thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         give_verdict();
      end
   end
   // ==========================================================
   // sequence
   initial begin
      tick(20);
      check(eq_mode, `EQ_ADAPTIVE);
      check(standby, 0);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         eq_select_strap_pu = rows[i].pu;
         eq_select_strap_pd = rows[i].pd;
         host_eq_valid = rows[i].hw;
         host_eq_mode = rows[i].hm;
         if (rows[i].hw) host_write();
         tick(8);
         check(eq_mode, rows[i].em);
         if (rows[i].em != `EQ_ADAPTIVE) check(eq_gain, rows[i].eg);
         $display("equalizer row %0d done", i);
      end
      // no link clock, detect still off: stays awake, audio passes
      tick(80);
      check(standby, 0);
      spdif_in = 1'b1;
      tick(8);
      check(audio_return_output, 1);
      spdif_in = 1'b0;
      tick(8);
      check(audio_return_output, 0);
      $display("audio and idle test done");
      signal_detect_enable = 1'b1;
      tick(80);
      check(standby, 1);
      check(link_out_oe, 0);
      check(rx_term_en, 0);
      // host override of detect both ways; blanking armed for the relock test
      host_sigdet_valid = 1'b1;
      host_blank_on_relock = 1'b1;
      host_write();
      tick(2);
      check(standby, 0);
      host_sigdet_en = 1'b1;
      host_write();
      tick(2);
      check(standby, 1);
      run = 1'b1;
      for (int k = 0; k < 3000 && standby !== 1'b0; k++) tick(1);
      check(standby, 0);
      check(rx_term_en, 1);
      check(tx_term_en, 0);
      // fast clock in automatic mode: relock with outputs blanked, then a locked retimer
      for (int k = 0; k < 3000 && retimer_active !== 1'b1; k++) tick(1);
      tick(2);
      check(link_out_oe, 0);
      check(locked, 0);
      tick(1200);
      check(retimer_active, 1);
      check(locked, 1);
      check(link_out_oe, 1);
      check(deemph, `DEEMPH_2DB);
      transmit_termination_strap_pd = 1'b0;
      slow = 1'b1;
      tick(3200);
      check(retimer_active, 0);
      check(cdr_en, 0);
      check(deemph, 0);
      check(tx_term_en, 0);
      $display("signal detect and auto mode test done");
      // forced retimer at a low rate, then forced redriver
      function_mode_field = `FMODE_RETIMER;
      host_outctl_valid = 1'b1;
      host_deemph = `DEEMPH_2DB;
      host_swing = `SWING_BOOST;
      host_force_lock = 1'b1;
      host_write();
      tick(8);
      check(retimer_active, 1);
      check(cdr_en, 1);
      check(locked, 1);
      check(deemph, `DEEMPH_2DB);
      check(swing, `SWING_BOOST);
      function_mode_field = `FMODE_REDRIVER;
      host_write();
      tick(1);
      check(retimer_active, 0);
      check(cdr_en, 0);
      check(deemph, 0);
      // back to back writes: the last one wins
      function_mode_field = `FMODE_RETIMER;
      host_wr = 1'b1;
      tick(1);
      function_mode_field = `FMODE_REDRIVER;
      tick(1);
      host_wr = 1'b0;
      tick(8);
      check(retimer_active, 0);
      $display("forced mode test done");
      host_audio_disable = 1'b1;
      host_write();
      spdif_in = 1'b1;
      tick(8);
      check(audio_return_output, 0);
      // start from the source, clock low, then the sink answers
      src_pull = 1'b1;
      tick(10);
      check(downstream_ddc_data_oe, 1);
      src_clk_pull = 1'b1;
      tick(8);
      check(downstream_ddc_clock_oe, 1);
      check(upstream_ddc_clock_oe, 1);
      src_pull = 1'b0;
      sink_pull = 1'b1;
      tick(20);
      check(upstream_ddc_data_oe, 1);
      sink_pull = 1'b0;
      src_clk_pull = 1'b0;
      tick(60);
      check(upstream_ddc_clock_oe, 1);
      tick(250);
      check(upstream_ddc_clock_oe, 0);
      check(downstream_ddc_clock_oe, 0);
      // faster rate: a short low phase is released well before the slow pacing would
      host_ddc_rate = `DDC_RATE_400K;
      host_write();
      src_clk_pull = 1'b1;
      tick(8);
      src_clk_pull = 1'b0;
      tick(80);
      check(upstream_ddc_clock_oe, 0);
      $display("audio disable and ddc test done");
      arst_n = 1'b0;
      tick(2);
      check(retimer_active, 0);
      check(eq_mode, `EQ_ADAPTIVE);
      arst_n = 1'b1;
      tick(8);
      check(audio_return_output, 1);
      $display("mid-run reset test done");
      give_verdict();
   end
endmodule // retimer_ctl_tb
